// ===== rtl/rtor_cfg.svh
// offsets, field positions, reset values and scale figures of the test and override bank
`ifndef RTOR_CFG_SVH
`define RTOR_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RTOR_OFF_COARSE 7'h63
`define RTOR_OFF_FINE 7'h64
`define RTOR_OFF_REG_EN 7'h65
`define RTOR_OFF_REG_LVL 7'h66
`define RTOR_OFF_ADC_T1 7'h67
`define RTOR_OFF_ADC_T2 7'h68
`define RTOR_OFF_GAIN 7'h69

// ------------------------------------------------------------
// reset values and writable-bit masks
// ------------------------------------------------------------
`define RTOR_RST_COARSE 8'h00
`define RTOR_RST_FINE 8'h00
`define RTOR_RST_REG_EN 8'h81
`define RTOR_RST_REG_LVL 8'h00
`define RTOR_RST_ADC_T1 8'h1d
`define RTOR_RST_ADC_T2 8'h00
`define RTOR_RST_GAIN 8'h20
`define RTOR_MSK_REG_LVL 8'hf7
`define RTOR_MSK_ADC_T2 8'h1f
`define RTOR_MSK_GAIN 8'h3f

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RTOR_B_CAL_OVR 7
`define RTOR_B_SPOR 7
`define RTOR_B_DIGPWDN 0
`define RTOR_B_GLB_OVR 7
`define RTOR_B_ADC_RST 7
`define RTOR_B_TUNE_OVR 4
`define RTOR_B_OLOOP 3
`define RTOR_B_AGC_EN 5
`define RTOR_B_LNA 4

// ------------------------------------------------------------
// gain and reference scale
// ------------------------------------------------------------
`define RTOR_LNA_MIN_DB 5'd5
`define RTOR_LNA_MAX_DB 5'd25
`define RTOR_PGA_STEP_DB 5'd3
`define RTOR_PGA_MAX_DB 5'd24
`define RTOR_PGA_MAX_CODE 4'h8
`define RTOR_REF_BASE_MV 11'd500
`define RTOR_REF_STEP_MV 11'd100

`endif

// ===== rtl/rtor_pkg.sv
// types of the test and override bank
package rtor_pkg;

	typedef enum logic [2:0] {
		RTOR_PS_LP = 3'h0,
		RTOR_PS_RDY = 3'h1,
		RTOR_PS_TUNE = 3'h3,
		RTOR_PS_TX = 3'h2,
		RTOR_PS_RX = 3'h7
	} rtor_pwr_e;

	typedef logic [7:0] rtor_byte_t;

endpackage

// ===== rtl/rtor_en_if.sv
// carrier between the bank and its block enable gate
`timescale 1ns/1ns
interface rtor_en_if #(parameter int N = 12);
	logic global_ovr;
	logic [N-1:0] ovr_val;
	logic [N-1:0] auto_en;
	logic [N-1:0] eff_en;
	modport ctrl (output global_ovr, output ovr_val, output auto_en, input eff_en);
	modport gate (input global_ovr, input ovr_val, input auto_en, output eff_en);
endinterface

// ===== rtl/rtor_ovr_sel.sv
// chooses between a host override value and an internal result
`timescale 1ns/1ns
module rtor_ovr_sel #(
	parameter int W = 7
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic ovr_en_i,
	input wire logic [W-1:0] host_i,
	input wire logic [W-1:0] int_i,
	output logic [W-1:0] view_o,
	output logic [W-1:0] eff_o
);
	logic [W-1:0] eff_d;

	assign eff_d = ovr_en_i ? host_i : int_i;
	assign view_o = eff_d;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eff_o <= '0;
		end else if (ce_i) begin
			eff_o <= eff_d;
		end
	end
endmodule // rtor_ovr_sel

// ===== rtl/rtor_en_gate.sv
// block enable gate: full override or force-on only
`timescale 1ns/1ns
module rtor_en_gate (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	rtor_en_if.gate en
);
	logic [$bits(en.eff_en)-1:0] eff_d;

	assign eff_d = en.global_ovr ? en.ovr_val : (en.ovr_val | en.auto_en);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en.eff_en <= '0;
		end else if (ce_i) begin
			en.eff_en <= eff_d;
		end
	end
endmodule // rtor_en_gate

// ===== rtl/rtor_bank.sv
// test and override register bank with calibration, enable and gain overrides
`timescale 1ns/1ns
`include "rtor_cfg.svh"

module rtor_bank
	import rtor_pkg::*;
#(
	parameter int N_EN = 12
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [6:0] coarse_cal_i,
	input wire logic [6:0] fine_cal_i,
	input wire logic [3:0] tune_cal_i,
	input wire logic [4:0] agc_gain_i,
	input wire logic [N_EN-1:0] auto_en_i,
	input wire logic [2:0] pwr_state_i,
	output logic [7:0] reg_rdata_o,
	output logic [6:0] rc_coarse_o,
	output logic [6:0] rc_fine_o,
	output logic [3:0] adc_tune_o,
	output logic [4:0] gain_o,
	output logic [4:0] lna_gain_db_o,
	output logic [4:0] pga_gain_db_o,
	output logic [10:0] adc_ref_mv_o,
	output logic [N_EN-1:0] block_en_o,
	output logic smart_por_en_o,
	output logic dig_pwdn_o,
	output logic [2:0] dig_lvl_o,
	output logic adc_rst_o,
	output logic adc_open_loop_o,
	output logic [2:0] pwr_state_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [4:0] pga_db(input logic [3:0] code);
		logic [4:0] v;
		v = (code >= `RTOR_PGA_MAX_CODE) ? `RTOR_PGA_MAX_DB : 5'(code * `RTOR_PGA_STEP_DB);
		return v;
	endfunction

	function automatic logic [10:0] ref_mv(input logic [2:0] code);
		return `RTOR_REF_BASE_MV + 11'(11'(code) * `RTOR_REF_STEP_MV);
	endfunction

	function automatic logic is_idle(input rtor_pwr_e s);
		return (s == RTOR_PS_LP) || (s == RTOR_PS_RDY);
	endfunction

	// ------------------------------------------------------------
	// registers and write decode
	// ------------------------------------------------------------
	rtor_byte_t coarse_q, fine_q, reg_en_q, reg_lvl_q, adc1_q, adc2_q, gain_q;
	rtor_pwr_e pwr_q, pwr_d;
	logic wr_coarse, wr_fine, wr_reg_en, wr_reg_lvl, wr_adc1, wr_adc2, wr_gain;
	logic [6:0] coarse_view, fine_view;
	logic [3:0] tune_view;
	logic [4:0] gain_view;
	rtor_byte_t rd_mux;

	assign wr_coarse = reg_wr_i && (reg_addr_i == `RTOR_OFF_COARSE);
	assign wr_fine = reg_wr_i && (reg_addr_i == `RTOR_OFF_FINE);
	assign wr_reg_en = reg_wr_i && (reg_addr_i == `RTOR_OFF_REG_EN);
	assign wr_reg_lvl = reg_wr_i && (reg_addr_i == `RTOR_OFF_REG_LVL);
	assign wr_adc1 = reg_wr_i && (reg_addr_i == `RTOR_OFF_ADC_T1);
	assign wr_adc2 = reg_wr_i && (reg_addr_i == `RTOR_OFF_ADC_T2);
	assign wr_gain = reg_wr_i && (reg_addr_i == `RTOR_OFF_GAIN);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			coarse_q <= `RTOR_RST_COARSE;
			fine_q <= `RTOR_RST_FINE;
			reg_en_q <= `RTOR_RST_REG_EN;
			reg_lvl_q <= `RTOR_RST_REG_LVL;
			adc1_q <= `RTOR_RST_ADC_T1;
			adc2_q <= `RTOR_RST_ADC_T2;
			gain_q <= `RTOR_RST_GAIN;
		end else if (ce_i) begin
			if (wr_coarse) coarse_q <= reg_wdata_i;
			if (wr_fine) fine_q <= reg_wdata_i;
			if (wr_reg_en) reg_en_q <= reg_wdata_i;
			if (wr_reg_lvl) reg_lvl_q <= reg_wdata_i & `RTOR_MSK_REG_LVL;
			if (wr_adc1) adc1_q <= reg_wdata_i;
			if (wr_adc2) adc2_q <= reg_wdata_i & `RTOR_MSK_ADC_T2;
			if (wr_gain) gain_q <= reg_wdata_i & `RTOR_MSK_GAIN;
		end
	end

	// ------------------------------------------------------------
	// override selectors
	// ------------------------------------------------------------
	rtor_ovr_sel #(.W(7)) u_coarse (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.ovr_en_i(coarse_q[`RTOR_B_CAL_OVR]),
		.host_i(coarse_q[6:0]),
		.int_i(coarse_cal_i),
		.view_o(coarse_view),
		.eff_o(rc_coarse_o)
	);

	rtor_ovr_sel #(.W(7)) u_fine (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.ovr_en_i(fine_q[`RTOR_B_CAL_OVR]),
		.host_i(fine_q[6:0]),
		.int_i(fine_cal_i),
		.view_o(fine_view),
		.eff_o(rc_fine_o)
	);

	rtor_ovr_sel #(.W(4)) u_tune (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.ovr_en_i(adc1_q[`RTOR_B_TUNE_OVR]),
		.host_i(adc1_q[3:0]),
		.int_i(tune_cal_i),
		.view_o(tune_view),
		.eff_o(adc_tune_o)
	);

	rtor_ovr_sel #(.W(5)) u_gain (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.ovr_en_i(!gain_q[`RTOR_B_AGC_EN]),
		.host_i(gain_q[4:0]),
		.int_i(agc_gain_i),
		.view_o(gain_view),
		.eff_o(gain_o)
	);

	// ------------------------------------------------------------
	// block enable gate
	// ------------------------------------------------------------
	rtor_en_if #(.N(N_EN)) en_bus ();

	assign en_bus.global_ovr = reg_lvl_q[`RTOR_B_GLB_OVR];
	assign en_bus.ovr_val = N_EN'({adc2_q[4], adc1_q[6:5], reg_lvl_q[6:4], reg_en_q[6:1]});
	assign en_bus.auto_en = auto_en_i;
	assign block_en_o = en_bus.eff_en;

	rtor_en_gate u_gate (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.en(en_bus.gate)
	);

	// ------------------------------------------------------------
	// power state tracking
	// ------------------------------------------------------------
	always_comb begin
		case (pwr_state_i)
			RTOR_PS_LP: pwr_d = RTOR_PS_LP;
			RTOR_PS_RDY: pwr_d = RTOR_PS_RDY;
			RTOR_PS_TUNE: pwr_d = RTOR_PS_TUNE;
			RTOR_PS_TX: pwr_d = RTOR_PS_TX;
			RTOR_PS_RX: pwr_d = RTOR_PS_RX;
			default: pwr_d = pwr_q;
		endcase
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	assign rd_mux =
		(reg_addr_i == `RTOR_OFF_COARSE) ? {coarse_q[7], coarse_view} :
		(reg_addr_i == `RTOR_OFF_FINE) ? {fine_q[7], fine_view} :
		(reg_addr_i == `RTOR_OFF_REG_EN) ? reg_en_q :
		(reg_addr_i == `RTOR_OFF_REG_LVL) ? reg_lvl_q :
		(reg_addr_i == `RTOR_OFF_ADC_T1) ? adc1_q :
		(reg_addr_i == `RTOR_OFF_ADC_T2) ? adc2_q :
		(reg_addr_i == `RTOR_OFF_GAIN) ? {gain_q[7:5], gain_view} :
		8'h00;

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
			pwr_q <= RTOR_PS_LP;
			lna_gain_db_o <= `RTOR_LNA_MIN_DB;
			pga_gain_db_o <= 5'h00;
			adc_ref_mv_o <= `RTOR_REF_BASE_MV;
			smart_por_en_o <= 1'b0;
			dig_pwdn_o <= 1'b0;
			dig_lvl_o <= 3'h0;
			adc_rst_o <= 1'b0;
			adc_open_loop_o <= 1'b0;
		end else if (ce_i) begin
			if (reg_rd_i) reg_rdata_o <= rd_mux;
			pwr_q <= pwr_d;
			lna_gain_db_o <= gain_view[`RTOR_B_LNA] ? `RTOR_LNA_MAX_DB : `RTOR_LNA_MIN_DB;
			pga_gain_db_o <= pga_db(gain_view[3:0]);
			adc_ref_mv_o <= ref_mv(adc2_q[2:0]);
			smart_por_en_o <= reg_en_q[`RTOR_B_SPOR];
			dig_pwdn_o <= reg_en_q[`RTOR_B_DIGPWDN] && is_idle(pwr_q);
			dig_lvl_o <= reg_lvl_q[2:0];
			adc_rst_o <= adc1_q[`RTOR_B_ADC_RST];
			adc_open_loop_o <= adc2_q[`RTOR_B_OLOOP];
		end
	end

	assign pwr_state_o = pwr_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic chk_live_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chk_live_q <= 1'b0;
		end else if (ce_i) begin
			chk_live_q <= 1'b1;
		end
	end

	// checks start one edge after reset release, when the outputs first leave reset
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i || !chk_live_q);

	a_coarse_read: assert property (ce_i && reg_rd_i && reg_addr_i == `RTOR_OFF_COARSE
		&& !coarse_q[7] |=> reg_rdata_o == {1'b0, $past(coarse_cal_i)})
		else $error("coarse read wrong");
	a_coarse_ovr: assert property (ce_i && coarse_q[7]
		|=> rc_coarse_o == $past(coarse_q[6:0])) else $error("coarse override lost");
	a_fine_read: assert property (ce_i && reg_rd_i && reg_addr_i == `RTOR_OFF_FINE
		&& !fine_q[7] |=> reg_rdata_o == {1'b0, $past(fine_cal_i)})
		else $error("fine read wrong");
	a_fine_ovr: assert property (ce_i && fine_q[7]
		|=> rc_fine_o == $past(fine_q[6:0])) else $error("fine override lost");
	a_enable_gate: assert property (ce_i |=> block_en_o == ($past(reg_lvl_q[7]) ?
		$past(en_bus.ovr_val) : ($past(en_bus.ovr_val) | $past(auto_en_i))))
		else $error("enable gate wrong");
	a_agc_gain: assert property (ce_i && gain_q[5]
		|=> gain_o == $past(agc_gain_i)) else $error("agc gain not followed");
	a_manual_gain: assert property (ce_i && !gain_q[5]
		|=> gain_o == $past(gain_q[4:0])) else $error("manual gain not followed");
	a_lna_db: assert property (ce_i
		|=> lna_gain_db_o == ($past(gain_view[4]) ? 5'd25 : 5'd5)) else $error("lna gain wrong");
	a_pga_db: assert property (ce_i && gain_view[3:0] == 4'h2
		|=> pga_gain_db_o == 5'd6) else $error("pga step wrong");
	a_pga_top: assert property (ce_i && gain_view[3:0] == 4'h8
		|=> pga_gain_db_o == 5'd24) else $error("pga top step wrong");
	a_pga_cap: assert property (pga_gain_db_o <= 5'd24) else $error("pga above cap");
	a_adc_ref: assert property (ce_i && adc2_q[2:0] == 3'h7
		|=> adc_ref_mv_o == 11'd1200) else $error("adc reference wrong");
	a_ref_base: assert property (ce_i && adc2_q[2:0] == 3'h0
		|=> adc_ref_mv_o == 11'd500) else $error("adc reference base wrong");
	a_reset_vals: assert property ($rose(rst_n_i) |-> reg_en_q == 8'h81
		&& adc1_q == 8'h1d && gain_q == 8'h20 && coarse_q == 8'h00)
		else $error("reset value wrong");
	a_dig_pwdn: assert property (ce_i && reg_en_q[0] && pwr_q == RTOR_PS_RX
		|=> !dig_pwdn_o) else $error("digital domain down outside idle");
	a_dig_idle: assert property (ce_i && reg_en_q[0] && pwr_q == RTOR_PS_LP
		|=> dig_pwdn_o) else $error("digital domain not down in idle");
	a_tune_ovr: assert property (ce_i && adc1_q[4]
		|=> adc_tune_o == $past(adc1_q[3:0])) else $error("tune override lost");
	a_tune_auto: assert property (ce_i && !adc1_q[4]
		|=> adc_tune_o == $past(tune_cal_i)) else $error("tune calibration not followed");
	a_pwr_code: assert property (pwr_state_o inside {3'h0, 3'h1, 3'h3, 3'h2, 3'h7})
		else $error("illegal power code");
	a_reserved_zero: assert property (ce_i && reg_rd_i && reg_addr_i == `RTOR_OFF_GAIN
		|=> reg_rdata_o[7:6] == 2'b00) else $error("reserved bits not zero");
	a_lvl_reserved: assert property (reg_lvl_q[3] == 1'b0)
		else $error("reserved level bit set");
	a_adc2_reserved: assert property (adc2_q[7:5] == 3'h0)
		else $error("reserved adc bits set");

	c_coarse_ovr: cover property (ce_i && wr_coarse && reg_wdata_i[7] ##1 coarse_q[7]);
	c_manual_gain: cover property (ce_i && wr_gain && !reg_wdata_i[5]);
	c_force_off: cover property (ce_i && reg_lvl_q[7] && |(auto_en_i & ~en_bus.ovr_val));
	c_idle_pwdn: cover property (dig_pwdn_o);
	c_write_frozen: cover property (!ce_i && reg_wr_i);

endmodule // rtor_bank

// ===== bench/rtor_host.sv
// host model driving the byte strobe register port
`timescale 1ns/1ns
module rtor_host (
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [6:0] addr_o,
	output logic [7:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 7'h00;
		wdata_o = 8'hff;
	end

	// one byte write, lines scrambled once released
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	// one byte read, data taken once it has settled
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_sys_i);
		#1 d = rdata_i;
	endtask
endmodule // rtor_host

// ===== bench/radio_test_override_regs_bench.sv
// self-checking bench of the test and override register bank
`timescale 1ns/1ns
module radio_test_override_regs_bench import rtor_pkg::*; ;
	// ----------
	// stimulus, design and host
	// ----------
	logic clk_sys_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i;
	logic [6:0] reg_addr_i, coarse_cal_i, fine_cal_i, rc_coarse_o, rc_fine_o;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic [3:0] tune_cal_i, adc_tune_o;
	logic [4:0] agc_gain_i, gain_o, lna_gain_db_o, pga_gain_db_o;
	logic [11:0] auto_en_i, block_en_o;
	logic [2:0] pwr_state_i, dig_lvl_o, pwr_state_o;
	logic [10:0] adc_ref_mv_o;
	logic smart_por_en_o, dig_pwdn_o, adc_rst_o, adc_open_loop_o;
	int bad_count = 0;
	int total_checks = 0;

	rtor_bank i_dut (.clk_sys_i, .rst_n_i, .ce_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
		.reg_wdata_i, .coarse_cal_i, .fine_cal_i, .tune_cal_i, .agc_gain_i, .auto_en_i,
		.pwr_state_i, .reg_rdata_o, .rc_coarse_o, .rc_fine_o, .adc_tune_o, .gain_o,
		.lna_gain_db_o, .pga_gain_db_o, .adc_ref_mv_o, .block_en_o, .smart_por_en_o,
		.dig_pwdn_o, .dig_lvl_o, .adc_rst_o, .adc_open_loop_o, .pwr_state_o);
	rtor_host i_host (.clk_sys_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
		.addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

	// ----------
	// helpers
	// ----------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, d);
		chk(16'(d), 16'(e));
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------
	// scenarios
	// ----------
	task automatic t_reset();
		chk(16'(adc_tune_o), 16'hd);
		chk(16'(gain_o), 16'(agc_gain_i));
		chk(16'(dig_pwdn_o), 16'h1);
		chk(16'(smart_por_en_o), 16'h1);
		chk(16'(adc_rst_o), 16'h0);
		chk(16'(block_en_o), 16'h0a5);
		rc(7'h63, {1'b0, coarse_cal_i});
		rc(7'h64, {1'b0, fine_cal_i});
		rc(7'h65, 8'h81);
		rc(7'h67, 8'h1d);
		rc(7'h69, {3'b001, agc_gain_i});
		rc(7'h6a, 8'h00);
	endtask

	task automatic t_cal();
		for (int i = 0; i < 2; i++) begin
			i_host.wr(7'h63 + 7'(i), 8'hd5);
			step(1);
			chk(16'(i ? rc_fine_o : rc_coarse_o), 16'h55);
			rc(7'h63 + 7'(i), 8'hd5);
			i_host.wr(7'h63 + 7'(i), 8'h2b);
			step(1);
			chk(16'(i ? rc_fine_o : rc_coarse_o), 16'(i ? fine_cal_i : coarse_cal_i));
			rc(7'h63 + 7'(i), {1'b0, i ? fine_cal_i : coarse_cal_i});
		end
	endtask

	task automatic t_tune();
		i_host.wr(7'h67, 8'he3);
		step(1);
		chk(16'(adc_tune_o), 16'(tune_cal_i));
		i_host.wr(7'h67, 8'h1a);
		step(1);
		chk(16'(adc_tune_o), 16'ha);
	endtask

	task automatic t_gain();
		for (int c = 0; c < 16; c++) begin
			i_host.wr(7'h69, 8'hc0 | 8'(c) | (c[0] ? 8'h10 : 8'h00));
			step(1);
			chk(16'(gain_o), 16'(c) | (c[0] ? 16'h10 : 16'h0));
			chk(16'(lna_gain_db_o), c[0] ? 16'd25 : 16'd5);
			chk(16'(pga_gain_db_o), c < 8 ? 16'(3 * c) : 16'd24);
		end
		rc(7'h69, 8'h1f);
		@(posedge clk_sys_i);
		agc_gain_i <= 5'h14;
		i_host.wr(7'h69, 8'he5);
		step(1);
		chk(16'(gain_o), 16'h14);
		rc(7'h69, 8'h34);
	endtask

	task automatic t_ref();
		for (int c = 0; c < 8; c++) begin
			i_host.wr(7'h68, 8'he0 | 8'(c) | (c[0] ? 8'h08 : 8'h00));
			step(1);
			chk(16'(adc_ref_mv_o), 16'(500 + 100 * c));
			chk(16'(adc_open_loop_o), 16'(c[0]));
		end
		rc(7'h68, 8'h0f);
	endtask

	task automatic t_gate();
		i_host.wr(7'h65, 8'h40);
		i_host.wr(7'h67, 8'h20);
		i_host.wr(7'h68, 8'h10);
		for (int g = 0; g < 2; g++) begin
			i_host.wr(7'h66, g ? 8'h3a : 8'hb2);
			step(1);
			chk(16'(block_en_o), g ? 16'hae5 : 16'hae0);
		end
		rc(7'h66, 8'h32);
		chk(16'(dig_lvl_o), 16'h2);
	endtask

	task automatic t_hold();
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		i_host.wr(7'h63, 8'hd5);
		step(2);
		chk(16'(rc_coarse_o), 16'(coarse_cal_i));
		@(posedge clk_sys_i);
		ce_i <= 1'b1;
		rc(7'h63, {1'b0, coarse_cal_i});
	endtask

	task automatic t_pwr();
		logic [2:0] st [6] = '{RTOR_PS_LP, RTOR_PS_RDY, RTOR_PS_TUNE, RTOR_PS_TX, RTOR_PS_RX, 3'h4};
		logic [2:0] e;
		i_host.wr(7'h65, 8'h01);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys_i);
			pwr_state_i <= st[k];
			step(3);
			e = (k == 5) ? 3'h7 : st[k];
			chk(16'(pwr_state_o), 16'(e));
			chk(16'(dig_pwdn_o), 16'(e < 3'h2));
		end
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		results();
	end

	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		coarse_cal_i = 7'h3c;
		fine_cal_i = 7'h19;
		tune_cal_i = 4'h6;
		agc_gain_i = 5'h0b;
		auto_en_i = 12'h0a5;
		pwr_state_i = 3'h0;
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		step(2);
		t_reset();
		t_cal();
		t_hold();
		t_tune();
		t_gain();
		t_ref();
		t_gate();
		t_pwr();
		results();
	end
endmodule // radio_test_override_regs_bench
